// ===== rtl/cmd_decoder.sv
// Top level: decodes external fastening commands into run, direction,
// counter and report actions. Assumes synchronous inputs, one clock.
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder (
    input wire logic clk,
    input wire logic resetn,
    input wire cmd_decoder_pkg::level_cmd_t lvl,
    input wire logic [cmd_decoder_pkg::PULSE_N-1:0] pulse_in,
    input wire cmd_decoder_pkg::config_t cfg,
    input wire logic ready_mode,
    input wire logic trigger_sw,
    input wire logic target_reached,
    input wire logic cycle_timeout,
    input wire logic multi_spindle,
    input wire logic error_set,
    input wire logic lock_set,
    output logic motor_run,
    output logic motor_reverse,
    output logic judge,
    output logic inhibit_active,
    output logic reverse_active,
    output logic system_error,
    output logic tool_locked,
    output logic job_started,
    output logic report_req,
    output logic seat_sync,
    output logic [cmd_decoder_pkg::CNT_W-1:0] batch_count,
    output logic [cmd_decoder_pkg::CNT_W-1:0] job_count
);
    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Counter plus one, wrapped at width
    function automatic logic [cmd_decoder_pkg::CNT_W-1:0] inc(
        input logic [cmd_decoder_pkg::CNT_W-1:0] v);
        inc = v + cmd_decoder_pkg::CNT_ONE;
    endfunction

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    cmd_decoder_pkg::cycle_state_t state_ff, nxt_state; // Cycle sequencer
    logic rev_ff, nxt_rev;              // Direction latched at start
    logic judge_ff, nxt_judge;          // One-cycle judgement strobe
    logic err_ff, nxt_err;              // System error status
    logic lock_ff, nxt_lock;            // Tool-lock from batch or job end
    logic jobst_ff, nxt_jobst;          // Captured job start
    logic report_ff, nxt_report;        // Report strobe to serial block
    logic seat_ff, nxt_seat;            // Seat sync strobe
    logic [cmd_decoder_pkg::CNT_W-1:0] batch_ff, nxt_batch; // Batch counter
    logic [cmd_decoder_pkg::CNT_W-1:0] job_ff, nxt_job;     // Job counter

    // ----------------------------------------------------------------
    // Edge detection
    // ----------------------------------------------------------------
    logic [cmd_decoder_pkg::PULSE_N-1:0] rise; // One cycle per press

    pulse_edge u_edge (
        .clk(clk),
        .resetn(resetn),
        .level_in(pulse_in),
        .rise(rise)
    );

    // ----------------------------------------------------------------
    // Qualifying conditions
    // ----------------------------------------------------------------
    wire rotating = (state_ff != cmd_decoder_pkg::ST_IDLE);
    // Either inhibit form blocks tool action, see [RL3] [RL5]
    wire blocked = lvl.inhibit | ~lvl.inhibit_nc_n;
    // Job gating: with line count on, a captured start is needed, see [RL12]
    wire job_ok = ~cfg.line_count_en | jobst_ff;
    // Reverse start barred by loosening disable, normal by tightening, see [RL16] [RL17]
    wire dir_ok = lvl.dir_reverse ? ~lvl.loosen_dis : ~lvl.tighten_dis;
    wire may_start = ready_mode & ~blocked & ~lock_ff & ~err_ff & job_ok & dir_ok;
    // Trigger switch shares the level-start path, see [RL3]
    wire lvl_start = may_start & (lvl.start | trigger_sw);
    wire pls_start = may_start & lvl.start_pulse;
    // Discard, job start, report, increment need ready and no rotation; clears need no rotation, counter reset ready, see [RL21]
    wire idle_rdy = ready_mode & ~rotating;
    wire do_err_clr = rise[cmd_decoder_pkg::P_ERR_CLR] & ~rotating;
    wire do_gen_rst = rise[cmd_decoder_pkg::P_GEN_RST] & ~rotating;
    wire do_discard = rise[cmd_decoder_pkg::P_DISCARD] & idle_rdy & cfg.discard_en;
    wire do_job_st = rise[cmd_decoder_pkg::P_JOB_START] & idle_rdy;
    wire do_report = rise[cmd_decoder_pkg::P_REPORT] & idle_rdy;
    wire do_cnt_inc = rise[cmd_decoder_pkg::P_CNT_INC] & idle_rdy;
    wire do_cnt_rst = rise[cmd_decoder_pkg::P_CNT_RST] & ready_mode
        & cfg.batch_count_setting;
    // Seat sync gated by start and nonzero pause, see [RL14]
    wire do_seat = rise[cmd_decoder_pkg::P_SEAT_SYNC] & lvl.start
        & (cfg.pause_time_setting != cmd_decoder_pkg::PAUSE_ZERO) & ~multi_spindle;

    // ----------------------------------------------------------------
    // Cycle sequencer
    // ----------------------------------------------------------------
    // Start, stop and judge
    always_comb begin
        nxt_state = state_ff;
        nxt_rev = rev_ff;
        nxt_judge = 1'b0;
        case (state_ff)
            cmd_decoder_pkg::ST_IDLE: begin
                if (lvl_start) begin
                    nxt_state = cmd_decoder_pkg::ST_RUN_LEVEL; // see [RL1]
                    nxt_rev = lvl.dir_reverse;                 // see [RL6]
                end else if (pls_start) begin
                    nxt_state = cmd_decoder_pkg::ST_RUN_PULSE; // see [RL18]
                    nxt_rev = lvl.dir_reverse;                 // see [RL6]
                end
            end
            cmd_decoder_pkg::ST_RUN_LEVEL: begin
                // Target, withdrawn start or inhibit all end and judge
                if (target_reached | ~(lvl.start | trigger_sw) | blocked) begin
                    nxt_state = cmd_decoder_pkg::ST_IDLE; // see [RL1] [RL2] [RL4]
                    nxt_judge = 1'b1;
                end
            end
            cmd_decoder_pkg::ST_RUN_PULSE: begin
                // Pulse release does not stop; only timeout or inhibit ends it before target
                if (target_reached | cycle_timeout | blocked) begin
                    nxt_state = cmd_decoder_pkg::ST_IDLE; // see [RL18] [RL4]
                    nxt_judge = 1'b1;
                end
            end
            default: begin
                nxt_state = cmd_decoder_pkg::ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Status flags
    // ----------------------------------------------------------------
    // Error and lock set wins over clear so a late event is never lost; general reset beats job start
    always_comb begin
        nxt_err = err_ff;
        nxt_lock = lock_ff;
        nxt_jobst = jobst_ff;
        if (do_err_clr | do_gen_rst) begin
            nxt_err = 1'b0;                 // see [RL8] [RL10]
            nxt_lock = 1'b0;                // see [RL8] [RL10]
        end
        if (do_gen_rst) begin
            nxt_jobst = 1'b0;               // see [RL11]
        end else if (do_job_st) begin
            nxt_jobst = 1'b1;               // see [RL12]
        end
        if (error_set) begin
            nxt_err = 1'b1;
        end
        if (lock_set) begin
            nxt_lock = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------
    // Reset beats load, load beats increment and discard
    always_comb begin
        nxt_batch = batch_ff;
        nxt_job = job_ff;
        if (do_gen_rst) begin
            if (cfg.batch_count_setting) begin
                nxt_batch = cmd_decoder_pkg::CNT_ZERO; // see [RL10]
            end
            if (cfg.job_en) begin
                nxt_job = cmd_decoder_pkg::CNT_ZERO;   // see [RL10]
            end
        end else if (do_cnt_rst) begin
            nxt_batch = cfg.batch_default;             // see [RL15]
        end else if (do_cnt_inc) begin
            // Job counter when jobs run, else batch, see [RL19]
            if (cfg.job_en) begin
                nxt_job = inc(job_ff);
            end else begin
                nxt_batch = inc(batch_ff);
            end
        end else if (do_discard) begin
            // Selection picks which counters advance, see [RL9]
            if (cfg.discard_selection_setting[cmd_decoder_pkg::SEL_BATCH]) begin
                nxt_batch = inc(batch_ff);
            end
            if (cfg.discard_selection_setting[cmd_decoder_pkg::SEL_JOB]) begin
                nxt_job = inc(job_ff);
            end
        end
    end

    // Strobes toward the serial port and seat logic
    assign nxt_report = do_report;          // see [RL13]
    assign nxt_seat = do_seat;              // see [RL14]

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Sequencer state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_ff <= cmd_decoder_pkg::ST_IDLE;
            rev_ff <= 1'b0;
            judge_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rev_ff <= nxt_rev;
            judge_ff <= nxt_judge;
        end
    end

    // Flags and strobes
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            err_ff <= 1'b0;
            lock_ff <= 1'b0;
            jobst_ff <= 1'b0;
            report_ff <= 1'b0;
            seat_ff <= 1'b0;
        end else begin
            err_ff <= nxt_err;
            lock_ff <= nxt_lock;
            jobst_ff <= nxt_jobst;
            report_ff <= nxt_report;
            seat_ff <= nxt_seat;
        end
    end

    // Counters
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            batch_ff <= cmd_decoder_pkg::CNT_ZERO;
            job_ff <= cmd_decoder_pkg::CNT_ZERO;
        end else begin
            batch_ff <= nxt_batch;
            job_ff <= nxt_job;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign motor_run = rotating;
    assign motor_reverse = rev_ff;
    assign judge = judge_ff;
    assign inhibit_active = lvl.inhibit;    // see [RL4]
    assign reverse_active = rotating & rev_ff; // see [RL7]
    assign system_error = err_ff;
    assign tool_locked = lock_ff;
    assign job_started = jobst_ff;
    assign report_req = report_ff;
    assign seat_sync = seat_ff;
    assign batch_count = batch_ff;
    assign job_count = job_ff;
endmodule
`default_nettype wire

// ===== rtl/cmd_decoder_pkg.sv
// Constants, types and encodings for the fastening input command decoder.
// Assumes all command inputs are already synchronous to clk.
//
// Contract
// [RL1] Level start runs cycle until target reached
// [RL2] Start withdrawn early stops and judges
// [RL3] Inhibit blocks start and trigger
// [RL4] Inhibit stops cycle, drives inhibit indication
// [RL5] Normally closed inhibit low disables actions
// [RL6] Direction select low normal, high reverse
// [RL7] Reverse indication during selected reverse rotation
// [RL8] Error clear clears errors and locks
// [RL9] Discard pulse updates counters per selection
// [RL10] General reset clears errors, counters, locks; code clears batch only with batch_count_setting, job only with job_en
// [RL11] General reset drops captured job start
// [RL12] Line count needs accepted job start
// [RL13] Report pulse sends latest result serially
// [RL14] Seat sync only with start, pause nonzero
// [RL15] Counter reset loads batch default value
// [RL16] Tightening disable blocks tightening only
// [RL17] Loosening disable blocks loosening only
// [RL18] Pulsed start runs until complete or inhibit
// [RL19] Count increment adds one to counter
// [RL20] Pulse inputs act once per edge
// [RL21] Restricted pulses during rotation are dropped
package cmd_decoder_pkg;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int CNT_W = 16;              // Counter width
    localparam int PULSE_N = 8;             // Number of pulse commands
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] PAUSE_ZERO = 16'h0000;

    // ----------------------------------------------------------------
    // Pulse command bit positions
    // ----------------------------------------------------------------
    localparam int P_ERR_CLR = 0;
    localparam int P_DISCARD = 1;
    localparam int P_GEN_RST = 2;
    localparam int P_JOB_START = 3;
    localparam int P_REPORT = 4;
    localparam int P_SEAT_SYNC = 5;
    localparam int P_CNT_RST = 6;
    localparam int P_CNT_INC = 7;

    // ----------------------------------------------------------------
    // Discard selection encodings (bit0 batch, bit1 job)
    // ----------------------------------------------------------------
    localparam int SEL_BATCH = 0;
    localparam int SEL_JOB = 1;

    // Cycle sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN_LEVEL = 3'b010,
        ST_RUN_PULSE = 3'b100
    } cycle_state_t;

    // Level command inputs from the line controller
    typedef struct packed {
        logic start;
        logic start_pulse;
        logic inhibit;
        logic inhibit_nc_n;
        logic dir_reverse;
        logic tighten_dis;
        logic loosen_dis;
    } level_cmd_t;

    // Configuration settings
    typedef struct packed {
        logic discard_en;
        logic [1:0] discard_selection_setting;
        logic line_count_en;
        logic batch_count_setting;
        logic job_en;
        logic [15:0] pause_time_setting;
        logic [15:0] batch_default;
    } config_t;

endpackage

// ===== rtl/pulse_edge.sv
// Rising edge detector for a group of pulse command inputs.
// Assumes inputs are synchronous to clk; a registered copy gives the edge.
`timescale 1ns/1ps
`default_nettype none
module pulse_edge (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [cmd_decoder_pkg::PULSE_N-1:0] level_in,
    output logic [cmd_decoder_pkg::PULSE_N-1:0] rise
);
    // ----------------------------------------------------------------
    // Previous level
    // ----------------------------------------------------------------
    logic [cmd_decoder_pkg::PULSE_N-1:0] prev_ff; // Last sampled level

    // Sample level each cycle; reset low so a held input fires once
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= level_in;
        end
    end

    // One pulse per rising edge however long held, see [RL20]
    assign rise = level_in & ~prev_ff;
endmodule
`default_nettype wire

// ===== tb/line_ctrl_model.sv
// Model of the external line controller driving the command inputs.
// Assumes a shared clock; every change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module line_ctrl_model (
    input wire logic clk,
    output var cmd_decoder_pkg::level_cmd_t lvl,
    output var logic [cmd_decoder_pkg::PULSE_N-1:0] pulse_in
);
    // ------------------------------------------------------------
    // Drive tasks, called by the bench at a rising edge
    // ------------------------------------------------------------
    initial begin
        lvl = '0;
        lvl.inhibit_nc_n = 1'b1;
        pulse_in = '0;
    end
    // Level commands change together at the calling edge
    task automatic set(input cmd_decoder_pkg::level_cmd_t v);
        lvl <= v;
    endtask
    // Held three cycles, then low three, so one edge must act once only
    task automatic pulse(input int b);
        pulse_in[b] <= 1'b1;
        repeat (3) @(posedge clk);
        pulse_in[b] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== tb/cmd_decoder_properties.sv
// Timing relations of the command decoder outputs.
// Assumes it is bound to the decoder top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cmd_decoder_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire cmd_decoder_pkg::level_cmd_t lvl,
    input wire logic [cmd_decoder_pkg::PULSE_N-1:0] pulse_in,
    input wire logic ready_mode,
    input wire logic target_reached,
    input wire logic motor_run,
    input wire logic motor_reverse,
    input wire logic judge,
    input wire logic inhibit_active,
    input wire logic reverse_active,
    input wire logic report_req
);
    // ------------------------------------------------------------
    // Properties, one clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    AST_INHIBIT_IND: assert property (inhibit_active == lvl.inhibit)
        else $error("inhibit indication differs from inhibit input");
    AST_INHIBIT_STOP: assert property (lvl.inhibit |=> !motor_run)
        else $error("rotation while inhibit held");
    AST_NC_STOP: assert property (!lvl.inhibit_nc_n |=> !motor_run)
        else $error("rotation while normally closed inhibit open");
    AST_TARGET_END: assert property (motor_run && target_reached |=> !motor_run)
        else $error("cycle did not end at target");
    AST_JUDGE: assert property (judge == $fell(motor_run))
        else $error("judge not tied to end of rotation");
    AST_DIR: assert property ($rose(motor_run)
        |-> motor_reverse == $past(lvl.dir_reverse))
        else $error("direction not taken from select at start");
    AST_TIGHT_DIS: assert property ($rose(motor_run) && !motor_reverse
        |-> !$past(lvl.tighten_dis))
        else $error("tightening started while disabled");
    AST_LOOSE_DIS: assert property ($rose(motor_run) && motor_reverse
        |-> !$past(lvl.loosen_dis))
        else $error("loosening started while disabled");
    AST_REV_IND: assert property (reverse_active == (motor_run && motor_reverse))
        else $error("reverse indication wrong");
    AST_REPORT: assert property ($rose(pulse_in[cmd_decoder_pkg::P_REPORT])
        && ready_mode && !motor_run |=> report_req)
        else $error("report pulse not answered");
    AST_REPORT_DROP: assert property ($rose(pulse_in[cmd_decoder_pkg::P_REPORT])
        && motor_run |=> !report_req)
        else $error("report taken during rotation");
    AST_ONE_SHOT: assert property (report_req |=> !report_req)
        else $error("report request longer than one cycle");
endmodule
bind cmd_decoder cmd_decoder_properties i_props (.clk(clk), .resetn(resetn), .lvl(lvl),
    .pulse_in(pulse_in), .ready_mode(ready_mode), .target_reached(target_reached),
    .motor_run(motor_run), .motor_reverse(motor_reverse), .judge(judge),
    .inhibit_active(inhibit_active), .reverse_active(reverse_active), .report_req(report_req));
`default_nettype wire

// ===== tb/test_cmd_decoder.sv
// Self-checking bench for the fastening command decoder.
// Assumes the line controller model drives all command inputs.
`timescale 1ns/1ps
`default_nettype none
module test_cmd_decoder;
    logic clk;
    logic resetn;
    cmd_decoder_pkg::level_cmd_t lvl;
    cmd_decoder_pkg::level_cmd_t lv; // Level image handed to the model
    logic [cmd_decoder_pkg::PULSE_N-1:0] pulse_in;
    cmd_decoder_pkg::config_t cfg;
    logic ready_mode, trigger_sw, target_reached, cycle_timeout;
    logic multi_spindle, error_set, lock_set;
    logic motor_run, motor_reverse, judge, inhibit_active, reverse_active;
    logic system_error, tool_locked, job_started, report_req, seat_sync;
    logic [cmd_decoder_pkg::CNT_W-1:0] batch_count, job_count;
    int err_count, compares, n_judge, n_rep, n_seat, j, r;
    // ------------------------------------------------------------
    // Instances, clock and one-cycle pulse counters
    // ------------------------------------------------------------
    line_ctrl_model i_ctrl (.clk(clk), .lvl(lvl), .pulse_in(pulse_in));
    cmd_decoder i_dut (.clk(clk), .resetn(resetn), .lvl(lvl), .pulse_in(pulse_in), .cfg(cfg),
        .ready_mode(ready_mode), .trigger_sw(trigger_sw), .target_reached(target_reached),
        .cycle_timeout(cycle_timeout), .multi_spindle(multi_spindle), .error_set(error_set),
        .lock_set(lock_set), .motor_run(motor_run), .motor_reverse(motor_reverse),
        .judge(judge), .inhibit_active(inhibit_active), .reverse_active(reverse_active),
        .system_error(system_error), .tool_locked(tool_locked), .job_started(job_started),
        .report_req(report_req), .seat_sync(seat_sync), .batch_count(batch_count),
        .job_count(job_count));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counted at the falling edge, where single-cycle pulses are settled
    always @(negedge clk) begin
        n_judge += int'(judge === 1'b1);
        n_rep += int'(report_req === 1'b1);
        n_seat += int'(seat_sync === 1'b1);
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bounded wait for rotation to reach a level; a hang ends the run
    task automatic wait_run(input logic v);
        int i;
        for (i = 0; i < 20 && motor_run !== v; i++) @(posedge clk);
        if (motor_run !== v) begin
            err_count++;
            results();
        end
    endtask
    task automatic apply(input int n);
        i_ctrl.set(lv);
        repeat (n) @(posedge clk);
    endtask
    task automatic go_idle;
        lv = '0;
        lv.inhibit_nc_n = 1'b1;
        apply(1);
        wait_run(1'b0);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_level;
        j = n_judge;
        r = n_seat;
        i_ctrl.pulse(cmd_decoder_pkg::P_SEAT_SYNC); // Start still low, so no sync
        check("seat_sync", 16'(n_seat - r), 16'h0000);
        s_start();
        check("motor_reverse", motor_reverse, 16'h0000);
        r = n_seat;
        i_ctrl.pulse(cmd_decoder_pkg::P_SEAT_SYNC);
        check("seat_sync", 16'(n_seat - r), 16'h0001);
        target_reached <= 1'b1;
        lv.start = 1'b0; // Dropped together so the cycle cannot relaunch
        apply(1);
        target_reached <= 1'b0;
        wait_run(1'b0);
        s_start();
        go_idle();
        repeat (2) @(posedge clk);
        check("judge", 16'(n_judge - j), 16'h0002);
    endtask
    task automatic s_start;
        lv.start = 1'b1;
        apply(1);
        wait_run(1'b1);
    endtask
    task automatic t_reverse;
        lv.dir_reverse = 1'b1;
        lv.tighten_dis = 1'b1;
        s_start();
        check("reverse_active", reverse_active, 16'h0001);
        go_idle();
        lv.tighten_dis = 1'b1;
        lv.start = 1'b1;
        apply(4);
        check("motor_run", motor_run, 16'h0000);
        go_idle();
        // Loosening refused, tightening still allowed
        lv.dir_reverse = 1'b1;
        lv.loosen_dis = 1'b1;
        lv.start = 1'b1;
        apply(4);
        check("motor_run", motor_run, 16'h0000);
        lv.dir_reverse = 1'b0;
        s_start();
        check("motor_reverse", motor_reverse, 16'h0000);
        go_idle();
    endtask
    task automatic t_inhibit;
        lv.start_pulse = 1'b1;
        apply(2);
        lv.start_pulse = 1'b0;
        apply(4);
        check("motor_run", motor_run, 16'h0001);
        lv.inhibit = 1'b1;
        lv.start = 1'b1;
        apply(3);
        check("motor_run", motor_run, 16'h0000);
        check("inhibit_active", inhibit_active, 16'h0001);
        lv.inhibit = 1'b0;
        lv.inhibit_nc_n = 1'b0;
        apply(3);
        check("motor_run", motor_run, 16'h0000);
        lv.inhibit_nc_n = 1'b1;
        apply(1);
        wait_run(1'b1);
        go_idle();
        // Trigger switch is refused under inhibit, then starts a cycle
        trigger_sw <= 1'b1;
        lv.inhibit = 1'b1;
        apply(3);
        check("motor_run", motor_run, 16'h0000);
        lv.inhibit = 1'b0;
        apply(1);
        wait_run(1'b1);
        trigger_sw <= 1'b0;
        go_idle();
        // Pulsed cycle ended by its timeout
        lv.start_pulse = 1'b1;
        apply(1);
        lv.start_pulse = 1'b0;
        apply(1);
        wait_run(1'b1);
        cycle_timeout <= 1'b1;
        @(posedge clk);
        cycle_timeout <= 1'b0;
        @(posedge clk);
        check("motor_run", motor_run, 16'h0000);
    endtask
    task automatic t_counts;
        i_ctrl.pulse(cmd_decoder_pkg::P_CNT_INC);
        i_ctrl.pulse(cmd_decoder_pkg::P_CNT_INC);
        check("batch_count", batch_count, 16'h0002);
        i_ctrl.pulse(cmd_decoder_pkg::P_DISCARD);
        check("batch_count", batch_count, 16'h0003);
        i_ctrl.pulse(cmd_decoder_pkg::P_CNT_RST);
        check("batch_count", batch_count, 16'h0005);
        ready_mode <= 1'b0;
        i_ctrl.pulse(cmd_decoder_pkg::P_CNT_INC);
        check("batch_count", batch_count, 16'h0005);
        ready_mode <= 1'b1;
        cfg.job_en <= 1'b1;
        i_ctrl.pulse(cmd_decoder_pkg::P_CNT_INC);
        check("job_count", job_count, 16'h0001);
        i_ctrl.pulse(cmd_decoder_pkg::P_GEN_RST);
        check("counts", batch_count | job_count, 16'h0000);
    endtask
    task automatic t_errors;
        error_set <= 1'b1;
        lock_set <= 1'b1;
        @(posedge clk);
        error_set <= 1'b0;
        lock_set <= 1'b0;
        @(posedge clk);
        check("error_lock", {system_error, tool_locked}, 16'h0003);
        i_ctrl.pulse(cmd_decoder_pkg::P_ERR_CLR);
        check("error_lock", {system_error, tool_locked}, 16'h0000);
    endtask
    task automatic t_report;
        r = n_rep;
        i_ctrl.pulse(cmd_decoder_pkg::P_REPORT);
        check("report", 16'(n_rep - r), 16'h0001);
        s_start();
        i_ctrl.pulse(cmd_decoder_pkg::P_REPORT);
        go_idle();
        repeat (3) @(posedge clk);
        check("report", 16'(n_rep - r), 16'h0001);
        cfg.line_count_en <= 1'b1;
        lv.start = 1'b1;
        apply(4);
        check("motor_run", motor_run, 16'h0000);
        i_ctrl.pulse(cmd_decoder_pkg::P_JOB_START);
        check("job_started", job_started, 16'h0001);
        wait_run(1'b1);
        go_idle();
        i_ctrl.pulse(cmd_decoder_pkg::P_GEN_RST);
        check("job_started", job_started, 16'h0000);
        cfg.line_count_en <= 1'b0;
    endtask
    initial begin
        resetn = 1'b0;
        cfg = '0;
        cfg.discard_en = 1'b1;
        cfg.discard_selection_setting = 2'h1;
        cfg.batch_count_setting = 1'b1;
        cfg.pause_time_setting = 16'h0003;
        cfg.batch_default = 16'h0005;
        {ready_mode, trigger_sw, target_reached, cycle_timeout} = 4'h8;
        {multi_spindle, error_set, lock_set} = 3'h0; // Single spindle
        lv = '0;
        lv.inhibit_nc_n = 1'b1;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_level();
        t_reverse();
        t_inhibit();
        t_counts();
        t_errors();
        t_report();
        results();
    end
endmodule
`default_nettype wire
